// File: hw/mpc_map.vh
/*
 motor parameter code and start-case constants: code field positions,
 reset values, start states and timing figures.
 assumes a 25 mhz system clock; included by bare name from hw/.
*/
`ifndef MPC_MAP_VH
`define MPC_MAP_VH

// code layout: mantissa in the low bits, shift amount above it
`define MPC_CODE_W 7
`define MPC_MANT_LSB 0
`define MPC_MANT_MSB 3
`define MPC_EXP_LSB 4
`define MPC_EXP_MSB 6
`define MPC_VAL_W 11
`define MPC_CODE_RST 7'h00
`define MPC_CODE_MAX 7'h7f
`define MPC_VAL_MAX 11'h780
`define MPC_VAL_MIN 11'h001
`define MPC_KT_SCALE 1090
`define MPC_RM_LSB_UOHM 9670

// initial motor condition
`define MPC_INIT_NONE 2'h0
`define MPC_INIT_STILL 2'h1
`define MPC_INIT_FWD 2'h2
`define MPC_INIT_REV 2'h3

// sequencer states
`define MPC_ST_IDLE 3'h0
`define MPC_ST_CLASSIFY 3'h1
`define MPC_ST_PROBE 3'h2
`define MPC_ST_ALIGN 3'h3
`define MPC_ST_ACCEL 3'h4
`define MPC_ST_CLOSED 3'h5
`define MPC_ST_COAST 3'h6

// timing
`define MPC_CLK_MHZ 25
`define MPC_ALIGN_TIME_US 100000
`define MPC_PROBE_TIMEOUT_US 100
`define MPC_PROBE_GAP_US 40
`define MPC_SECTORS 6

`endif

// File: hw/mpc_code_decode.v
/*
 holds one 7-bit mantissa/exponent motor parameter code and decodes it.
 assumes load_i is a one-cycle strobe synchronous to clk_i.
*/
`timescale 1ns/100ps
`include "mpc_map.vh"

module mpc_code_decode
#(
  parameter CODE_W = 7,
  parameter VAL_W = 11
)
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // code load
  input wire load_i,
  input wire [CODE_W-1:0] code_i,
  // decoded result
  output reg [CODE_W-1:0] code_o,
  output reg [VAL_W-1:0] value_o,
  output reg bad_o
);

  wire [3:0] mant_w;
  wire [2:0] exp_w;
  wire [VAL_W-1:0] val_d;
  wire bad_d;

  assign mant_w = code_i[`MPC_MANT_MSB:`MPC_MANT_LSB];
  assign exp_w = code_i[`MPC_EXP_MSB:`MPC_EXP_LSB];
  assign val_d = {{(VAL_W-4){1'b0}}, mant_w} << exp_w;
  assign bad_d = (exp_w != 3'h0) && !mant_w[3];

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      code_o <= `MPC_CODE_RST;
      value_o <= {VAL_W{1'b0}};
      bad_o <= 1'b0;
    end
    else if (load_i)
    begin
      code_o <= code_i;
      value_o <= val_d;
      bad_o <= bad_d;
    end
  end

endmodule // mpc_code_decode

// File: hw/mpc_cycle_timer.v
/*
 one-shot cycle timer: counts limit_i cycles after start_i, then pulses done_o.
 assumes limit_i is held steady while busy_o is high.
*/
`timescale 1ns/100ps

module mpc_cycle_timer
#(
  parameter CNT_W = 22
)
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // control
  input wire start_i,
  input wire abort_i,
  input wire [CNT_W-1:0] limit_i,
  // status
  output reg busy_o,
  output reg done_o,
  output reg [CNT_W-1:0] count_o
);

  always @(posedge clk_i)
  begin
    if (rst_i || abort_i)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      count_o <= {CNT_W{1'b0}};
    end
    else if (start_i)
    begin
      busy_o <= 1'b1;
      done_o <= 1'b0;
      count_o <= {CNT_W{1'b0}};
    end
    else if (busy_o)
    begin
      count_o <= count_o + {{(CNT_W-1){1'b0}}, 1'b1};
      if (count_o + {{(CNT_W-1){1'b0}}, 1'b1} >= limit_i)
      begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end
    end
    else
    begin
      done_o <= 1'b0;
    end
  end

endmodule // mpc_cycle_timer

// File: hw/mpc_start_case.v
/*
 motor parameter code holder and start-case sequencer: decodes the phase
 resistance and bemf constant codes, classifies the initial motor state and
 aligns commutation by inductive probing, forced alignment or resync.
 assumes motion, direction and probe current inputs come from the analog
 front end, synchronous to clock_i.
*/
`timescale 1ns/100ps
`include "mpc_map.vh"

// Functional notes
// - hold bemf constant as 7-bit code
// - bemf value is mantissa shifted by exponent
// - code 0x7f decodes to 1920 maximum
// - code 0x01 decodes to 1 minimum
// - bemf codes follow table, 0x00 is zero
// - decode resistance code 0x00 to 0x7f
// - classify motor still, forward or reverse
// - still motor: probe or forced alignment
// - probe finds rotor by inductance variation
// - align drives chosen phase before accelerating
// - fast forward motor resyncs into closed loop
// - resistance value is mantissa shifted by exponent
module mpc_start_case
#(
  parameter ALIGN_CYCLES = `MPC_ALIGN_TIME_US * `MPC_CLK_MHZ,
  parameter PROBE_GAP_CYCLES = `MPC_PROBE_GAP_US * `MPC_CLK_MHZ,
  parameter PROBE_TIMEOUT_CYCLES = `MPC_PROBE_TIMEOUT_US * `MPC_CLK_MHZ,
  parameter TMR_W = 22
)
(
  // clock and reset
  input wire clock_i,
  input wire sys_rst_i,
  // parameter codes from configuration storage
  input wire param_load_i,
  input wire [6:0] phase_resistance_code_i,
  input wire [6:0] bemf_constant_code_i,
  // start options
  input wire start_i,
  input wire stop_i,
  input wire probe_select_i,
  input wire resync_enable_i,
  input wire [1:0] align_phase_i,
  // motion sensing
  input wire motor_moving_i,
  input wire motor_forward_i,
  input wire speed_above_resync_i,
  input wire [2:0] measured_sector_i,
  input wire probe_current_hit_i,
  input wire accel_done_i,
  // decoded parameters
  output reg [6:0] phase_resistance_code_o,
  output reg [10:0] phase_resistance_value_o,
  output reg [6:0] bemf_constant_code_o,
  output reg [10:0] bemf_digital_value_o,
  output reg param_error_o,
  // start status and drive requests
  output reg [1:0] initial_state_o,
  output reg [2:0] start_state_o,
  output reg rotor_position_probe_o,
  output reg [2:0] probe_sector_o,
  output reg align_drive_o,
  output reg [1:0] align_phase_o,
  output reg accel_o,
  output reg closed_loop_o,
  output reg [2:0] commut_sector_o
);

  localparam [TMR_W-1:0] ALIGN_LIM = ALIGN_CYCLES[TMR_W-1:0];
  localparam [TMR_W-1:0] GAP_LIM = PROBE_GAP_CYCLES[TMR_W-1:0];
  localparam [TMR_W-1:0] TIMEOUT_LIM = PROBE_TIMEOUT_CYCLES[TMR_W-1:0];
  localparam integer SECTOR_COUNT = `MPC_SECTORS;
  localparam [2:0] LAST_SECTOR = SECTOR_COUNT[2:0] - 3'h1;

  wire [6:0] rm_code_w;
  wire [10:0] rm_val_w;
  wire rm_bad_w;
  wire [6:0] kt_code_w;
  wire [10:0] kt_val_w;
  wire kt_bad_w;

  reg [2:0] state_q, state_d;
  reg [1:0] init_q, init_d;
  reg [2:0] sector_q, sector_d;
  reg [2:0] best_q, best_d;
  reg [TMR_W-1:0] best_time_q, best_time_d;
  reg pulsing_q, pulsing_d;
  reg [2:0] start_sector_q, start_sector_d;
  reg tmr_start;
  reg [TMR_W-1:0] tmr_limit;
  wire tmr_busy;
  wire tmr_done;
  wire [TMR_W-1:0] tmr_count;
  wire abort_w;

  mpc_code_decode #(.CODE_W(`MPC_CODE_W), .VAL_W(`MPC_VAL_W)) u_rm_decode
  (
    .clk_i(clock_i),
    .rst_i(sys_rst_i),
    .load_i(param_load_i),
    .code_i(phase_resistance_code_i),
    .code_o(rm_code_w),
    .value_o(rm_val_w),
    .bad_o(rm_bad_w)
  );

  mpc_code_decode #(.CODE_W(`MPC_CODE_W), .VAL_W(`MPC_VAL_W)) u_kt_decode
  (
    .clk_i(clock_i),
    .rst_i(sys_rst_i),
    .load_i(param_load_i),
    .code_i(bemf_constant_code_i),
    .code_o(kt_code_w),
    .value_o(kt_val_w),
    .bad_o(kt_bad_w)
  );

  assign abort_w = stop_i && (state_q != `MPC_ST_IDLE);

  mpc_cycle_timer #(.CNT_W(TMR_W)) u_timer
  (
    .clk_i(clock_i),
    .rst_i(sys_rst_i),
    .start_i(tmr_start),
    .abort_i(abort_w),
    .limit_i(tmr_limit),
    .busy_o(tmr_busy),
    .done_o(tmr_done),
    .count_o(tmr_count)
  );

  // sequencer next state
  always @*
  begin
    state_d = state_q;
    init_d = init_q;
    sector_d = sector_q;
    best_d = best_q;
    best_time_d = best_time_q;
    pulsing_d = pulsing_q;
    start_sector_d = start_sector_q;
    tmr_start = 1'b0;
    tmr_limit = TIMEOUT_LIM;
    if (stop_i)
    begin
      state_d = `MPC_ST_IDLE;
      init_d = `MPC_INIT_NONE;
      pulsing_d = 1'b0;
    end
    else
    begin
      case (state_q)
        `MPC_ST_IDLE:
          // start refused while either code is unusable
          if (start_i && !rm_bad_w && !kt_bad_w)
            state_d = `MPC_ST_CLASSIFY;
        `MPC_ST_CLASSIFY:
        begin
          if (!motor_moving_i)
          begin
            init_d = `MPC_INIT_STILL;
            if (probe_select_i)
            begin
              state_d = `MPC_ST_PROBE;
              sector_d = 3'h0;
              best_d = 3'h0;
              best_time_d = {TMR_W{1'b1}};
              pulsing_d = 1'b1;
              tmr_start = 1'b1;
              tmr_limit = TIMEOUT_LIM;
            end
            else
            begin
              state_d = `MPC_ST_ALIGN;
              tmr_start = 1'b1;
              tmr_limit = ALIGN_LIM;
            end
          end
          else if (motor_forward_i)
          begin
            init_d = `MPC_INIT_FWD;
            if (resync_enable_i && speed_above_resync_i)
            begin
              state_d = `MPC_ST_CLOSED;
              start_sector_d = measured_sector_i;
            end
            else
              state_d = `MPC_ST_COAST;
          end
          else
          begin
            init_d = `MPC_INIT_REV;
            state_d = `MPC_ST_COAST;
          end
        end
        // a moving motor that is not resynced coasts until it stops
        `MPC_ST_COAST:
          if (!motor_moving_i)
            state_d = `MPC_ST_CLASSIFY;
        // inductive probe, shortest current rise wins
        `MPC_ST_PROBE:
        begin
          tmr_limit = pulsing_q ? TIMEOUT_LIM : GAP_LIM;
          if (pulsing_q && (probe_current_hit_i || tmr_done))
          begin
            if (probe_current_hit_i && (tmr_count < best_time_q))
            begin
              best_time_d = tmr_count;
              best_d = sector_q;
            end
            pulsing_d = 1'b0;
            tmr_start = 1'b1;
            tmr_limit = GAP_LIM;
          end
          else if (!pulsing_q && tmr_done)
          begin
            if (sector_q == LAST_SECTOR)
            begin
              state_d = `MPC_ST_ACCEL;
              start_sector_d = best_q;
            end
            else
            begin
              sector_d = sector_q + 3'h1;
              pulsing_d = 1'b1;
              tmr_start = 1'b1;
              tmr_limit = TIMEOUT_LIM;
            end
          end
        end
        `MPC_ST_ALIGN:
        begin
          tmr_limit = ALIGN_LIM;
          if (tmr_done)
          begin
            state_d = `MPC_ST_ACCEL;
            start_sector_d = {align_phase_o, 1'b0};
          end
        end
        `MPC_ST_ACCEL:
          if (accel_done_i)
            state_d = `MPC_ST_CLOSED;
        `MPC_ST_CLOSED:
          state_d = `MPC_ST_CLOSED;
        default:
          state_d = `MPC_ST_IDLE;
      endcase
    end
  end

  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= `MPC_ST_IDLE;
      init_q <= `MPC_INIT_NONE;
      sector_q <= 3'h0;
      best_q <= 3'h0;
      best_time_q <= {TMR_W{1'b1}};
      pulsing_q <= 1'b0;
      start_sector_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      init_q <= init_d;
      sector_q <= sector_d;
      best_q <= best_d;
      best_time_q <= best_time_d;
      pulsing_q <= pulsing_d;
      start_sector_q <= start_sector_d;
    end
  end

  // registered outputs
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      phase_resistance_code_o <= `MPC_CODE_RST;
      phase_resistance_value_o <= 11'h000;
      bemf_constant_code_o <= `MPC_CODE_RST;
      bemf_digital_value_o <= 11'h000;
      param_error_o <= 1'b0;
      initial_state_o <= `MPC_INIT_NONE;
      start_state_o <= `MPC_ST_IDLE;
      rotor_position_probe_o <= 1'b0;
      probe_sector_o <= 3'h0;
      align_drive_o <= 1'b0;
      align_phase_o <= 2'h0;
      accel_o <= 1'b0;
      closed_loop_o <= 1'b0;
      commut_sector_o <= 3'h0;
    end
    else
    begin
      phase_resistance_code_o <= rm_code_w;
      phase_resistance_value_o <= rm_val_w;
      bemf_constant_code_o <= kt_code_w;
      bemf_digital_value_o <= kt_val_w;
      param_error_o <= rm_bad_w || kt_bad_w;
      initial_state_o <= init_d;
      start_state_o <= state_d;
      rotor_position_probe_o <= (state_d == `MPC_ST_PROBE) && pulsing_d;
      probe_sector_o <= sector_d;
      align_drive_o <= (state_d == `MPC_ST_ALIGN);
      // phase latched when alignment starts, held during it
      if (state_q != `MPC_ST_ALIGN)
        align_phase_o <= align_phase_i;
      accel_o <= (state_d == `MPC_ST_ACCEL);
      closed_loop_o <= (state_d == `MPC_ST_CLOSED);
      commut_sector_o <= start_sector_d;
    end
  end

endmodule // mpc_start_case

// File: tb/mpc_start_case_asserts.sv
/*
 port checker for the start-case block.
 assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/100ps
module mpc_start_case_asserts (
  // clock, reset and inputs
  input wire clock_i, sys_rst_i, param_load_i, stop_i, probe_select_i,
  input wire resync_enable_i, motor_moving_i, motor_forward_i, speed_above_resync_i,
  input wire [6:0] phase_resistance_code_i, bemf_constant_code_i,
  input wire [2:0] measured_sector_i,
  // outputs
  input wire [6:0] phase_resistance_code_o, bemf_constant_code_o,
  input wire [10:0] phase_resistance_value_o, bemf_digital_value_o,
  input wire param_error_o, align_drive_o, accel_o, closed_loop_o,
  input wire [1:0] initial_state_o,
  input wire [2:0] start_state_o, commut_sector_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_classify;
    start_state_o == 3'h1 && !stop_i;
  endsequence
  property p_kt_val;
    bemf_digital_value_o == ({7'h00, bemf_constant_code_o[3:0]} << bemf_constant_code_o[6:4]);
  endproperty
  a_kt_val: assert property (p_kt_val) else $error("bemf value wrong");
  property p_rm_val;
    phase_resistance_value_o ==
      ({7'h00, phase_resistance_code_o[3:0]} << phase_resistance_code_o[6:4]);
  endproperty
  a_rm_val: assert property (p_rm_val) else $error("resistance value wrong");
  property p_kt_load;
    param_load_i |-> ##2 bemf_constant_code_o == $past(bemf_constant_code_i, 2);
  endproperty
  a_kt_load: assert property (p_kt_load) else $error("bemf code not held");
  property p_rm_load;
    param_load_i |-> ##2 phase_resistance_code_o == $past(phase_resistance_code_i, 2);
  endproperty
  a_rm_load: assert property (p_rm_load) else $error("resistance code not held");
  property p_err;
    param_error_o == ((phase_resistance_code_o[6:4] != 3'h0 && !phase_resistance_code_o[3])
      || (bemf_constant_code_o[6:4] != 3'h0 && !bemf_constant_code_o[3]));
  endproperty
  a_err: assert property (p_err) else $error("code error flag wrong");
  property p_still;
    s_classify ##0 !motor_moving_i |=> initial_state_o == 2'h1
      && start_state_o == ($past(probe_select_i) ? 3'h2 : 3'h3);
  endproperty
  a_still: assert property (p_still) else $error("still motor path wrong");
  property p_resync;
    s_classify ##0 (motor_moving_i && motor_forward_i && resync_enable_i
      && speed_above_resync_i) |=> closed_loop_o && commut_sector_o == $past(measured_sector_i);
  endproperty
  a_resync: assert property (p_resync) else $error("resync path wrong");
  property p_align;
    align_drive_o && !stop_i |=> align_drive_o || (accel_o && start_state_o == 3'h4);
  endproperty
  a_align: assert property (p_align) else $error("align not followed by accel");
endmodule // mpc_start_case_asserts

bind mpc_start_case mpc_start_case_asserts u_chk (.clock_i, .sys_rst_i, .param_load_i,
  .stop_i, .probe_select_i, .resync_enable_i, .motor_moving_i, .motor_forward_i,
  .speed_above_resync_i, .phase_resistance_code_i, .bemf_constant_code_i,
  .measured_sector_i, .phase_resistance_code_o, .bemf_constant_code_o,
  .phase_resistance_value_o, .bemf_digital_value_o, .param_error_o, .align_drive_o,
  .accel_o, .closed_loop_o, .initial_state_o, .start_state_o, .commut_sector_o);

// File: tb/mpc_motor_model.sv
/*
 motor windings and front end: probe current, spin sector, accel done.
 assumes the bench sets the rotor sector.
*/
`timescale 1ns/100ps
module mpc_motor_model (
  // drive requests
  input wire clock_i, probe_i, accel_i,
  input wire [2:0] rotor_i, probe_sector_i,
  // sensing
  output reg [2:0] measured_sector_o,
  output wire probe_current_hit_o, accel_done_o
);
  reg [3:0] hit_cnt_q;
  reg [2:0] acc_cnt_q;
  initial
  begin
    hit_cnt_q = 4'h0;
    acc_cnt_q = 3'h0;
    measured_sector_o = 3'h0;
  end
  always @(posedge clock_i)
  begin
    measured_sector_o <= (measured_sector_o == 3'h5) ? 3'h0 : measured_sector_o + 3'h1;
    hit_cnt_q <= probe_i ? hit_cnt_q + 4'h1 : 4'h0;
    acc_cnt_q <= accel_i ? acc_cnt_q + 3'h1 : 3'h0;
  end
  assign probe_current_hit_o = probe_i && hit_cnt_q >= ((probe_sector_i == rotor_i) ? 4'h3 : 4'h7);
  assign accel_done_o = acc_cnt_q >= 3'h4;
endmodule // mpc_motor_model

// File: tb/mpc_start_case_test.sv
/*
 self-checking bench for the start-case block.
 assumes the motor model on the sensing inputs.
*/
`timescale 1ns/100ps
module mpc_start_case_test;
  localparam AL = 20;
  reg clock_i, sys_rst_i, param_load_i, start_i, stop_i, probe_select_i, resync_enable_i;
  reg motor_moving_i, motor_forward_i, speed_above_resync_i;
  reg [6:0] rm_c, kt_c;
  reg [1:0] aph;
  reg [2:0] rotor;
  wire [6:0] rm_o, kt_o;
  wire [10:0] rm_v, kt_v;
  wire err_o, probe_o, align_o, accel_o, closed_o, hit, adone;
  wire [1:0] init_o, aph_o;
  wire [2:0] st_o, psec_o, csec_o, msec;
  integer fail_count, n_checks, i, c, n;
  integer cyc = 0;

  mpc_start_case #(.ALIGN_CYCLES(AL), .PROBE_GAP_CYCLES(8), .PROBE_TIMEOUT_CYCLES(16),
    .TMR_W(22)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .param_load_i(param_load_i),
    .phase_resistance_code_i(rm_c), .bemf_constant_code_i(kt_c), .start_i(start_i),
    .stop_i(stop_i), .probe_select_i(probe_select_i), .resync_enable_i(resync_enable_i),
    .align_phase_i(aph), .motor_moving_i(motor_moving_i), .motor_forward_i(motor_forward_i),
    .speed_above_resync_i(speed_above_resync_i), .measured_sector_i(msec),
    .probe_current_hit_i(hit), .accel_done_i(adone), .phase_resistance_code_o(rm_o),
    .phase_resistance_value_o(rm_v), .bemf_constant_code_o(kt_o),
    .bemf_digital_value_o(kt_v), .param_error_o(err_o), .initial_state_o(init_o),
    .start_state_o(st_o), .rotor_position_probe_o(probe_o), .probe_sector_o(psec_o),
    .align_drive_o(align_o), .align_phase_o(aph_o), .accel_o(accel_o),
    .closed_loop_o(closed_o), .commut_sector_o(csec_o));
  mpc_motor_model u_motor (.clock_i(clock_i), .probe_i(probe_o), .accel_i(accel_o),
    .rotor_i(rotor), .probe_sector_i(psec_o), .measured_sector_o(msec),
    .probe_current_hit_o(hit), .accel_done_o(adone));

  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  function integer val(input integer k);
    val = (k % 16) << (k / 16);
  endfunction
  function integer bad(input integer k);
    bad = (k / 16 != 0) && (k % 16 < 8);
  endfunction
  // host side: smallest shift that leaves a 4-bit mantissa
  function integer enc(input integer v);
    integer s;
  begin
    s = 0;
    while ((v >> s) > 15)
      s = s + 1;
    enc = (s << 4) | (v >> s);
  end
  endfunction

  task chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  end
  endtask
  task summarize;
  begin
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task load(input [6:0] r, input [6:0] k);
  begin
    @(posedge clock_i);
    param_load_i <= 1'b1;
    rm_c <= r;
    kt_c <= k;
    @(posedge clock_i);
    param_load_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    chk("rm code", {4'h0, rm_o}, {4'h0, r});
    chk("rm value", rm_v, 11'(val(r)));
    chk("kt code", {4'h0, kt_o}, {4'h0, k});
    chk("kt value", kt_v, 11'(val(k)));
    chk("code error", {10'h0, err_o}, 11'(bad(r) || bad(k)));
  end
  endtask
  // host scales physical constants, encodes and loads them
  task host(input integer kt_mv, input integer rm_mohm);
    integer kd, rd;
  begin
    kd = kt_mv * 1090 / 1000;
    rd = rm_mohm * 1000 / 9670;
    load(7'(enc(rd)), 7'(enc(kd)));
    chk("kt scaled", 11'(kt_v <= kd && (kd - kt_v) * 8 <= kt_v), 11'h001);
    chk("rm scaled", 11'(rm_v <= rd && (rd - rm_v) * 8 <= rm_v), 11'h001);
  end
  endtask
  task go;
  begin
    @(posedge clock_i);
    start_i <= 1'b1;
    @(posedge clock_i);
    start_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
  end
  endtask
  task halt;
  begin
    @(posedge clock_i);
    stop_i <= 1'b1;
    @(posedge clock_i);
    stop_i <= 1'b0;
  end
  endtask
  task wait_accel;
  begin
    i = 0;
    c = 0;
    while (accel_o !== 1'b1 && i < 400)
    begin
      @(negedge clock_i);
      c = c + align_o;
      i = i + 1;
    end
  end
  endtask

  always @(posedge clock_i)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      summarize;
    end
  end

  initial
  begin
    {sys_rst_i, param_load_i, start_i, stop_i, probe_select_i, resync_enable_i} = 6'h20;
    {motor_moving_i, motor_forward_i, speed_above_resync_i} = 3'h0;
    rm_c = 7'h00;
    kt_c = 7'h00;
    aph = 2'h0;
    rotor = 3'h0;
    fail_count = 0;
    n_checks = 0;
    n = $urandom(86882);
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    load(7'h7f, 7'h7f);
    chk("kt max", kt_v, 11'h780);
    load(7'h01, 7'h00);
    chk("kt zero", kt_v, 11'h000);
    load(7'h00, 7'h01);
    chk("kt min", kt_v, 11'h001);
    for (n = 0; n < 24; n = n + 1)
      load($urandom % 128, $urandom % 128);
    $display("decode test done");
    host(1760, 18500);
    for (n = 0; n < 8; n = n + 1)
      host($urandom % 1761, $urandom % 18501);
    $display("scaling test done");
    load(7'h17, 7'h10);
    go;
    chk("refused start", {8'h0, st_o}, 11'h000);
    load(7'h2b, 7'h5c);
    $display("refuse test done");
    @(posedge clock_i);
    rotor <= $urandom % 6;
    probe_select_i <= 1'b1;
    go;
    chk("still state", {8'h0, st_o}, 11'h002);
    chk("still init", {9'h0, init_o}, 11'h001);
    chk("probe pulse", {10'h0, probe_o}, 11'h001);
    chk("first sector", {8'h0, psec_o}, 11'h000);
    wait_accel;
    chk("probe sector", {8'h0, csec_o}, {8'h0, rotor});
    halt;
    $display("probe test done");
    @(posedge clock_i);
    probe_select_i <= 1'b0;
    aph <= $urandom % 3;
    go;
    wait_accel;
    chk("align length", 11'(c >= AL && c <= AL + 2), 11'h001);
    chk("align phase", {9'h0, aph_o}, {9'h0, aph});
    chk("align sector", {8'h0, csec_o}, {8'h0, aph, 1'b0});
    halt;
    $display("align test done");
    @(posedge clock_i);
    {motor_moving_i, motor_forward_i, speed_above_resync_i, resync_enable_i} <= 4'hf;
    go;
    chk("resync state", {8'h0, st_o}, 11'h005);
    chk("resync init", {9'h0, init_o}, 11'h002);
    chk("resync loop", {10'h0, closed_o}, 11'h001);
    halt;
    $display("resync test done");
    @(posedge clock_i);
    resync_enable_i <= 1'b0;
    go;
    chk("coast state", {8'h0, st_o}, 11'h006);
    chk("coast init", {9'h0, init_o}, 11'h002);
    halt;
    $display("coast test done");
    @(posedge clock_i);
    motor_forward_i <= 1'b0;
    go;
    chk("reverse state", {8'h0, st_o}, 11'h006);
    chk("reverse init", {9'h0, init_o}, 11'h003);
    @(posedge clock_i);
    motor_moving_i <= 1'b0;
    repeat (3) @(negedge clock_i);
    chk("stopped state", {8'h0, st_o}, 11'h003);
    chk("stopped init", {9'h0, init_o}, 11'h001);
    halt;
    $display("reverse test done");
    summarize;
  end
endmodule // mpc_start_case_test
